/* File: rtl/smw_consts.svh */
`ifndef SMW_CONSTS_SVH
`define SMW_CONSTS_SVH
// ****************************************
// widths and encodings
// ****************************************
`define SMW_MW_8          2'h0
`define SMW_MW_16         2'h1
`define SMW_MW_32         2'h2
`define SMW_SIZE_BYTE     3'h0
`define SMW_SIZE_HALF     3'h1
`define SMW_SIZE_WORD     3'h2
`define SMW_RESP_OKAY     1'h0
`define SMW_RESP_ERROR    1'h1
// ****************************************
// timing counts and reset values
// ****************************************
`define SMW_WAIT_W        5
`define SMW_EXT_W         14
`define SMW_TURN_W        4
`define SMW_CNT_W         15
`define SMW_SYNC_STAGES   3
`define SMW_PIN_IDLE      1'h1
`endif

/* File: rtl/smw_pkg.sv */
package smw_pkg;
  // per-bank configuration
  typedef struct packed {
    logic [1:0]  memory_width_field;
    logic        byte_lane_read_level;
    logic        guard_flag;
    logic        slow_timing_flag;
    logic        buffer_enable;
    logic [3:0]  output_enable_delay;
    logic [4:0]  read_wait_count;
    logic [3:0]  write_enable_delay;
    logic [4:0]  write_wait_count;
    logic [3:0]  turnaround_field;
    logic [13:0] extended_wait_count;
  } smw_bank_cfg_t;

  // system bus request
  typedef struct packed {
    logic        write;
    logic [2:0]  size;
    logic [2:0]  bank;
    logic [25:0] addr;
    logic [31:0] wdata;
  } smw_req_t;

  // memory pins, low-active strobes
  typedef struct packed {
    logic [5:0]  chip_select_n;
    logic        output_enable_n;
    logic        write_enable_n;
    logic [3:0]  byte_lane_enable_n;
    logic [23:0] addr;
    logic [31:0] dout;
    logic        dout_en_n;
  } smw_pins_t;

  typedef enum logic [4:0] {
    SMW_IDLE = 5'h01,
    SMW_TURN = 5'h02,
    SMW_RD   = 5'h04,
    SMW_WR   = 5'h08,
    SMW_HOLD = 5'h10
  } smw_state_t;
endpackage

/* File: rtl/smw_sync.sv */
`timescale 1ns/100ps
`include "smw_consts.svh"
// ****************************************
// three-stage synchroniser, change taken when stages two and three agree
// ****************************************
module smw_sync #(
  parameter logic RESET_VAL = 1'h1
) (
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  input  wire logic d_in,
  output logic      q_out
);
  logic [`SMW_SYNC_STAGES-1:0] sync_q;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync_q <= {`SMW_SYNC_STAGES{RESET_VAL}};
    end else begin
      sync_q <= {sync_q[`SMW_SYNC_STAGES-2:0], d_in};
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q_out <= RESET_VAL;
    end else if (sync_q[1] == sync_q[2]) begin
      q_out <= sync_q[2];
    end
  end
endmodule

/* File: rtl/smw_lanes.sv */
`timescale 1ns/100ps
`include "smw_consts.svh"
// ****************************************
// byte-lane and address decode, purely combinational
// ****************************************
module smw_lanes (
  input  wire logic [1:0]  width_in,
  input  wire logic [2:0]  size_in,
  input  wire logic [25:0] addr_in,
  input  wire logic        write_in,
  input  wire logic        read_level_in,
  output logic      [3:0]  lanes_n_out,
  output logic      [23:0] ext_addr_out
);
  logic [3:0] wmask;

  always_comb begin
    wmask = 4'hf;
    unique case (size_in)
      `SMW_SIZE_BYTE: wmask = 4'h1 << addr_in[1:0];
      `SMW_SIZE_HALF: wmask = addr_in[1] ? 4'hc : 4'h3;
      default:        wmask = 4'hf;
    endcase
    // narrow bank: lanes above the bank width are never used on writes
    if (width_in == `SMW_MW_8) begin
      wmask = 4'h1;
    end else if (width_in == `SMW_MW_16) begin
      wmask = {2'h0, wmask[1:0] | wmask[3:2]};
    end
    if (write_in) begin
      lanes_n_out = ~wmask;
    end else begin
      lanes_n_out = {4{~read_level_in}};
    end
  end

  always_comb begin
    unique case (width_in)
      `SMW_MW_16: ext_addr_out = addr_in[24:1];
      `SMW_MW_32: ext_addr_out = addr_in[25:2];
      default:    ext_addr_out = addr_in[23:0];
    endcase
  end
endmodule

/* File: rtl/smw_ctrl.sv */
`timescale 1ns/100ps
`include "smw_consts.svh"
// Functional notes
// - output enable follows chip select after output_enable_delay clock periods.
// - read extended by read_wait_count wait states, one period each.
// - read length is oe delay plus one plus read waits; no chip select hold.
// - write strobe always starts at least one period after chip select.
// - write strobe ends one plus write_wait_count periods after initial delay.
// - write_enable_delay postpones strobe start without lengthening the cycle.
// - address and chip select held one period after write strobe ends.
// - turnaround cycles between reads of different banks and read then write.
// - byte lanes from size and bank width; low address bits decoded on writes.
// - accesses wider than a word get an error response.
// - each bank is 8, 16 or 32 bits wide.
// - reads drive all byte lanes to one common level.
// - read level cleared keeps lanes high; set drives them low.
// - width code 01 is 16-bit, 10 is 32-bit; address shifted right.
// - each bank has its own write-protect flag.
// - wait input sampled every cycle; it only holds the access at the last count.
// - normal wait counters allow up to 31 wait states.
// - slow timing flag uses one extended count for reads and writes.
// - an enabled bank buffer is used by every access to that bank.
module smw_ctrl #(
  parameter int NUM_BANKS = 6
) (
  input  wire logic                  clk_in,
  input  wire logic                  arst_n_in,
  input  wire smw_pkg::smw_bank_cfg_t cfg_in [NUM_BANKS],
  input  wire logic                  req_valid_in,
  input  wire smw_pkg::smw_req_t     req_in,
  input  wire logic                  external_wait_n_in,
  input  wire logic [31:0]           mem_din_in,
  output logic                       req_ready_out,
  output logic                       resp_valid_out,
  output logic                       resp_error_out,
  output logic [31:0]                rdata_out,
  output logic                       buffer_used_out,
  output smw_pkg::smw_pins_t         pins_out
);
  initial begin
    if (NUM_BANKS < 1 || NUM_BANKS > 6) begin
      $error("smw_ctrl: NUM_BANKS must be 1 to 6");
    end
  end

  // ****************************************
  // state
  // ****************************************
  smw_pkg::smw_state_t    state_q;
  smw_pkg::smw_req_t      cur_q;
  smw_pkg::smw_bank_cfg_t ccfg_q;
  logic [`SMW_CNT_W-1:0]  cnt_q;
  logic [`SMW_CNT_W-1:0]  strobe_on_q;
  logic [`SMW_CNT_W-1:0]  strobe_off_q;
  logic [`SMW_TURN_W:0]   turn_q;
  logic                   last_read_q;
  logic [2:0]             last_bank_q;
  logic                   wait_ok;
  logic [3:0]             lanes_n;
  logic [23:0]            ext_addr;
  smw_pkg::smw_bank_cfg_t bcfg;
  logic                   too_wide;
  logic                   protected_wr;
  logic                   need_turn;
  logic                   accept;
  logic                   done;

  smw_sync #(
    .RESET_VAL (1'h1)
  ) u_wait_sync (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .d_in      (external_wait_n_in),
    .q_out     (wait_ok)
  );

  smw_lanes u_lanes (
    .width_in      (ccfg_q.memory_width_field),
    .size_in       (cur_q.size),
    .addr_in       (cur_q.addr),
    .write_in      (cur_q.write),
    .read_level_in (ccfg_q.byte_lane_read_level),
    .lanes_n_out   (lanes_n),
    .ext_addr_out  (ext_addr)
  );

  // ****************************************
  // request decode
  // ****************************************
  always_comb begin
    bcfg = cfg_in[0];
    if (int'(req_in.bank) < NUM_BANKS) begin
      bcfg = cfg_in[req_in.bank];
    end
    too_wide     = req_in.size > `SMW_SIZE_WORD;
    protected_wr = req_in.write & bcfg.guard_flag;
    // turnaround after a read when the next is a write or another bank's read
    need_turn = last_read_q & (req_in.write | (req_in.bank != last_bank_q));
    accept = (state_q == smw_pkg::SMW_IDLE) & req_valid_in;
  end

  // access ends on the last counted period unless wait holds it
  assign done = (cnt_q == strobe_off_q) & wait_ok;

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q      <= smw_pkg::SMW_IDLE;
      cur_q        <= '0;
      ccfg_q       <= '0;
      cnt_q        <= '0;
      strobe_on_q  <= '0;
      strobe_off_q <= '0;
      turn_q       <= '0;
    end else begin
      unique case (state_q)
        smw_pkg::SMW_IDLE: begin
          if (accept && !too_wide && !protected_wr) begin
            cur_q  <= req_in;
            ccfg_q <= bcfg;
            cnt_q  <= '0;
            if (bcfg.slow_timing_flag) begin
              // one extended count times both directions
              strobe_off_q <= `SMW_CNT_W'(bcfg.extended_wait_count);
              strobe_on_q  <= req_in.write ? `SMW_CNT_W'(1) : '0;
            end else if (req_in.write) begin
              strobe_on_q  <= `SMW_CNT_W'(bcfg.write_enable_delay) + `SMW_CNT_W'(1);
              // last count is the chip select hold period after the strobe
              strobe_off_q <= `SMW_CNT_W'(bcfg.write_wait_count) + `SMW_CNT_W'(2);
            end else begin
              strobe_on_q  <= `SMW_CNT_W'(bcfg.output_enable_delay);
              strobe_off_q <= `SMW_CNT_W'(bcfg.output_enable_delay)
                              + `SMW_CNT_W'(bcfg.read_wait_count);
            end
            if (need_turn) begin
              turn_q  <= {1'h0, cfg_in_turn(bcfg)} + 5'h1;
              state_q <= smw_pkg::SMW_TURN;
            end else begin
              state_q <= req_in.write ? smw_pkg::SMW_WR : smw_pkg::SMW_RD;
            end
          end
        end
        smw_pkg::SMW_TURN: begin
          turn_q <= turn_q - 5'h1;
          if (turn_q == 5'h1) begin
            state_q <= cur_q.write ? smw_pkg::SMW_WR : smw_pkg::SMW_RD;
          end
        end
        smw_pkg::SMW_RD, smw_pkg::SMW_WR: begin
          // wait input low holds the access at the last count; earlier counts run on regardless
          if (done) begin
            state_q <= smw_pkg::SMW_HOLD;
          end else if (cnt_q != strobe_off_q) begin
            cnt_q <= cnt_q + `SMW_CNT_W'(1);
          end
        end
        smw_pkg::SMW_HOLD: begin
          state_q <= smw_pkg::SMW_IDLE;
        end
      endcase
    end
  end

  function automatic logic [3:0] cfg_in_turn(input smw_pkg::smw_bank_cfg_t c);
    cfg_in_turn = c.turnaround_field;
  endfunction

  // ****************************************
  // turnaround history
  // ****************************************
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      last_read_q <= 1'h0;
      last_bank_q <= '0;
    end else if (state_q == smw_pkg::SMW_HOLD) begin
      last_read_q <= ~cur_q.write;
      last_bank_q <= cur_q.bank;
    end
  end

  // ****************************************
  // memory pins, all registered
  // ****************************************
  logic active;
  logic strobe;
  assign active = (state_q == smw_pkg::SMW_RD) | (state_q == smw_pkg::SMW_WR);
  // a write strobe only exists while on-point is not past off-point
  // reads keep output enable through the last count; writes drop the strobe for the hold
  assign strobe = active & (cnt_q >= strobe_on_q) & (~done | ~cur_q.write);

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pins_out <= '{chip_select_n: 6'h3f, output_enable_n: `SMW_PIN_IDLE,
                    write_enable_n: `SMW_PIN_IDLE, byte_lane_enable_n: 4'hf,
                    addr: 24'h0, dout: 32'h0, dout_en_n: `SMW_PIN_IDLE};
    end else begin
      pins_out.chip_select_n <= 6'h3f;
      if (active) begin
        pins_out.chip_select_n[cur_q.bank] <= 1'h0;
      end
      pins_out.addr      <= ext_addr;  // held through the hold period
      pins_out.dout      <= cur_q.wdata;
      pins_out.dout_en_n <= ~((state_q == smw_pkg::SMW_WR) | (state_q == smw_pkg::SMW_HOLD
                             & cur_q.write));
      pins_out.output_enable_n <= ~(strobe & ~cur_q.write);
      pins_out.write_enable_n  <= ~(strobe & cur_q.write);
      if (cur_q.write) begin
        pins_out.byte_lane_enable_n <= strobe ? lanes_n : 4'hf;
      end else begin
        pins_out.byte_lane_enable_n <= active ? lanes_n : 4'hf;
      end
    end
  end

  // ****************************************
  // bus answer
  // ****************************************
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      req_ready_out   <= 1'h0;
      resp_valid_out  <= 1'h0;
      resp_error_out  <= `SMW_RESP_OKAY;
      rdata_out       <= 32'h0;
      buffer_used_out <= 1'h0;
    end else begin
      req_ready_out  <= (state_q == smw_pkg::SMW_IDLE) & ~req_valid_in;
      resp_valid_out <= (accept & (too_wide | protected_wr)) |
                        (state_q == smw_pkg::SMW_HOLD);
      resp_error_out <= accept & (too_wide | protected_wr);
      // pins lag the state by one cycle, so the last output enable period ends here
      if ((state_q == smw_pkg::SMW_HOLD) & ~cur_q.write) begin
        rdata_out <= mem_din_in;  // data latched at end of the strobe
      end
      // buffered bank: access marked as passing the buffer
      buffer_used_out <= active & ccfg_q.buffer_enable;
    end
  end
endmodule

/* File: tb/smw_ctrl_props.sv */
`timescale 1ns/100ps
// ****
// port checker
// ****
module smw_ctrl_props #(
  parameter int NUM_BANKS = 6
) (
  input wire logic                   clk_in,
  input wire logic                   arst_n_in,
  input wire smw_pkg::smw_bank_cfg_t cfg_in [NUM_BANKS],
  input wire logic                   req_valid_in,
  input wire smw_pkg::smw_req_t      req_in,
  input wire logic                   resp_valid_out,
  input wire logic                   resp_error_out,
  input wire smw_pkg::smw_pins_t     pins_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  logic cs_on;
  assign cs_on = pins_out.chip_select_n != 6'h3f;
  a_oe_in_cs: assert property (!pins_out.output_enable_n |-> cs_on)
    else $error("output enable outside chip select");
  a_addr_steady: assert property (cs_on && $past(cs_on) |-> $stable(pins_out.addr))
    else $error("address moved inside an access");
  a_we_late: assert property ($fell(pins_out.write_enable_n) |-> $past(cs_on))
    else $error("write strobe with chip select");
  a_cs_hold: assert property ($rose(pins_out.write_enable_n) |-> cs_on)
    else $error("chip select not held after strobe");
  a_read_lanes: assert property (!pins_out.output_enable_n |->
    pins_out.byte_lane_enable_n inside {4'h0, 4'hf}) else $error("mixed lanes on read");
  a_size_error: assert property ($rose(req_valid_in) && req_in.size > 3'h2
    |-> !cs_on ##[1:3] (resp_valid_out && resp_error_out)) else $error("wide access taken");
  a_guard_block: assert property ($rose(req_valid_in) && req_in.write &&
    cfg_in[req_in.bank].guard_flag |=> (!cs_on && pins_out.write_enable_n) [*4])
    else $error("protected bank written");
  a_resp_pulse: assert property (resp_valid_out |=> !resp_valid_out)
    else $error("response longer than a cycle");
endmodule
bind smw_ctrl smw_ctrl_props #(.NUM_BANKS(NUM_BANKS)) smw_ctrl_props_i (.clk_in, .arst_n_in,
  .cfg_in, .req_valid_in, .req_in, .resp_valid_out, .resp_error_out, .pins_out);

/* File: tb/smw_mem_model.sv */
`timescale 1ns/100ps
// ****
// asynchronous memory on the far side
// ****
module smw_mem_model (
  input  wire logic               clk_in,
  input  wire smw_pkg::smw_pins_t pins_in,
  input  wire logic [3:0]         stall_in,
  output logic [31:0]             data_out,
  output logic                    wait_n_out
);
  logic [31:0] mem [16];
  logic [31:0] last_q = 32'h0;
  logic [4:0]  age_q = 5'h0;
  logic        we_q = 1'h1;
  logic [3:0]  lanes_q = 4'hf;
  logic        cs_on;
  assign cs_on = pins_in.chip_select_n != 6'h3f;
  // released bus shows the inverse of the last word, so stale data never passes
  assign data_out = (cs_on && !pins_in.output_enable_n) ? mem[pins_in.addr[3:0]] : ~last_q;
  // wait pulls low straight from chip select, released once ready
  assign wait_n_out = !(cs_on && age_q < {1'h0, stall_in});
  always @(posedge clk_in) begin
    age_q <= cs_on ? age_q + 5'h1 : 5'h0;
    we_q <= pins_in.write_enable_n;
    lanes_q <= pins_in.byte_lane_enable_n;
    if (!pins_in.output_enable_n) last_q <= data_out;
    for (int i = 0; i < 4; i++) if (!we_q && pins_in.write_enable_n && !lanes_q[i])
      mem[pins_in.addr[3:0]][8*i+:8] <= pins_in.dout[8*i+:8];
  end
endmodule

/* File: tb/smw_ctrl_tb.sv */
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin failures++; \
  $display("BAD %s expected %0h seen %0h", nm, ex, got); end end
// ****
// scenario bench
// ****
module smw_ctrl_tb;
  logic                   clk_in;
  logic                   arst_n_in;
  logic                   req_valid_in;
  logic                   resp_v;
  logic                   resp_e;
  logic                   err;
  logic                   bu;
  logic                   buf_used;
  logic                   wait_n;
  logic                   ready;
  logic [3:0]             stall;
  logic [3:0]             rd_lanes;
  logic [3:0]             wr_lanes;
  logic [23:0]            ext_addr;
  logic [31:0]            din;
  logic [31:0]            rdata;
  smw_pkg::smw_bank_cfg_t cfg [6];
  smw_pkg::smw_req_t      req;
  smw_pkg::smw_pins_t     pins;
  int                     failures;
  int                     comparisons;
  int                     cs_cnt;
  int                     oe_cnt;
  int                     we_cnt;
  int                     lat;
  int                     la;
  smw_ctrl smw_ctrl_i (.clk_in(clk_in), .arst_n_in(arst_n_in), .cfg_in(cfg),
    .req_valid_in(req_valid_in), .req_in(req), .external_wait_n_in(wait_n), .mem_din_in(din),
    .req_ready_out(ready), .resp_valid_out(resp_v), .resp_error_out(resp_e),
    .rdata_out(rdata), .buffer_used_out(buf_used), .pins_out(pins));
  smw_mem_model smw_mem_model_i (.clk_in(clk_in), .pins_in(pins), .stall_in(stall),
    .data_out(din), .wait_n_out(wait_n));
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  // outputs are sampled mid-cycle, away from the launching edge
  always @(negedge clk_in) begin
    if (pins.chip_select_n != 6'h3f) begin
      cs_cnt++;
      ext_addr = pins.addr;
      bu = buf_used;
    end
    if (!pins.output_enable_n) begin
      oe_cnt++;
      rd_lanes = pins.byte_lane_enable_n;
    end
    if (!pins.write_enable_n) begin
      we_cnt++;
      wr_lanes = pins.byte_lane_enable_n;
    end
  end
  task automatic base();
    // buffers off for flash-like writes
    for (int i = 0; i < 6; i++) cfg[i] = '{memory_width_field: 2'h2, default: '0};
  endtask
  task automatic xfer(input logic w, input logic [2:0] s, input logic [2:0] b,
                      input logic [25:0] a, input logic [31:0] d);
    @(negedge clk_in);
    cs_cnt = 0;
    oe_cnt = 0;
    we_cnt = 0;
    lat = 0;
    req = '{w, s, b, a, d};
    req_valid_in = 1'b1;
    while (resp_v !== 1'b1 && lat < 20000) begin
      @(negedge clk_in);
      lat++;
    end
    err = resp_e;
    req_valid_in = 1'b0;
    repeat (3) @(negedge clk_in);
  endtask
  task automatic t_read();
    logic [3:0] oed [4] = '{4'h0, 4'h0, 4'h1, 4'h0};
    logic [4:0] rwc [4] = '{5'h0, 5'h3, 5'h2, 5'h1f};
    for (int i = 0; i < 4; i++) begin
      base();
      cfg[0].output_enable_delay = oed[i];
      cfg[0].read_wait_count = rwc[i];
      cfg[0].byte_lane_read_level = i[0];
      xfer(1'b0, 3'h2, 3'h0, 26'h0, 32'h0);
      `CHK("read cs", int'(oed[i]) + int'(rwc[i]) + 1, cs_cnt)
      `CHK("read oe", int'(rwc[i]) + 1, oe_cnt)
      `CHK("read lanes", i[0] ? 4'h0 : 4'hf, rd_lanes)
    end
  endtask
  task automatic t_write();
    logic [3:0] wed [4] = '{4'h0, 4'h0, 4'h2, 4'h1};
    logic [4:0] wwc [4] = '{5'h0, 5'h2, 5'h2, 5'h1f}; // never below the delay
    for (int i = 0; i < 4; i++) begin
      base();
      cfg[0].write_enable_delay = wed[i];
      cfg[0].write_wait_count = wwc[i];
      xfer(1'b1, 3'h2, 3'h0, 26'h0, 32'h0);
      `CHK("write cs", int'(wwc[i]) + 3, cs_cnt)
      `CHK("write we", int'(wwc[i]) - int'(wed[i]) + 1, we_cnt)
    end
  endtask
  task automatic t_lanes();
    logic [1:0]  w [6] = '{2'h2, 2'h2, 2'h2, 2'h1, 2'h1, 2'h0};
    logic [2:0]  s [6] = '{3'h2, 3'h0, 3'h1, 3'h0, 3'h1, 3'h0};
    logic [25:0] a [6] = '{26'h10, 26'h12, 26'h12, 26'h11, 26'h12, 26'h13};
    logic [3:0]  l [6] = '{4'h0, 4'hb, 4'h3, 4'hd, 4'hc, 4'he};
    logic [23:0] x [6] = '{24'h4, 24'h4, 24'h4, 24'h8, 24'h9, 24'h13};
    base();
    for (int i = 0; i < 6; i++) begin
      cfg[2].memory_width_field = w[i];
      xfer(1'b1, s[i], 3'h2, a[i], 32'h0);
      `CHK("lanes", l[i], wr_lanes)
      `CHK("pin addr", x[i], ext_addr)
    end
    base();
    xfer(1'b1, 3'h2, 3'h0, 26'h8, 32'ha5c3_1e7f);
    xfer(1'b0, 3'h2, 3'h0, 26'h8, 32'h0);
    `CHK("rdata", 32'ha5c3_1e7f, rdata)
  endtask
  task automatic t_refuse();
    base();
    `CHK("ready idle", 1'b1, ready)
    cfg[3].guard_flag = 1'b1;
    xfer(1'b0, 3'h3, 3'h0, 26'h0, 32'h0);
    `CHK("size err", 1'b1, err)
    `CHK("size cs", 0, cs_cnt)
    xfer(1'b1, 3'h2, 3'h3, 26'h0, 32'h0);
    `CHK("guard err", 1'b1, err)
    `CHK("guard we", 0, we_cnt)
    xfer(1'b0, 3'h2, 3'h3, 26'h0, 32'h0);
    `CHK("guard read", 1'b0, err)
    xfer(1'b1, 3'h2, 3'h0, 26'h0, 32'h0);
    `CHK("open write", 1'b0, err)
  endtask
  task automatic t_turn();
    base();
    cfg[0].turnaround_field = 4'h3;
    cfg[1].turnaround_field = 4'h3;
    xfer(1'b1, 3'h2, 3'h1, 26'h0, 32'h0);
    xfer(1'b0, 3'h2, 3'h1, 26'h0, 32'h0);
    la = lat;
    xfer(1'b0, 3'h2, 3'h0, 26'h0, 32'h0);
    xfer(1'b0, 3'h2, 3'h1, 26'h0, 32'h0);
    `CHK("turn rr", la + 4, lat)
    xfer(1'b1, 3'h2, 3'h1, 26'h0, 32'h0);
    la = lat;
    xfer(1'b1, 3'h2, 3'h1, 26'h0, 32'h0);
    `CHK("turn rw", la - 4, lat)
  endtask
  task automatic t_slow();
    base();
    cfg[0].read_wait_count = 5'h8;
    stall = 4'hc;
    xfer(1'b0, 3'h2, 3'h0, 26'h0, 32'h0);
    `CHK("wait ext", 1'b1, cs_cnt > 11)
    stall = 4'h0;
    cfg[4].slow_timing_flag = 1'b1;
    cfg[4].extended_wait_count = 14'h3ff0;
    cfg[5].buffer_enable = 1'b1;
    xfer(1'b0, 3'h2, 3'h4, 26'h0, 32'h0);
    `CHK("slow read", 1'b1, cs_cnt >= 16368)
    xfer(1'b1, 3'h2, 3'h4, 26'h0, 32'h0);
    `CHK("slow write", 1'b1, cs_cnt >= 16368)
    xfer(1'b0, 3'h2, 3'h5, 26'h0, 32'h0);
    `CHK("buffer", 1'b1, bu)
    xfer(1'b0, 3'h2, 3'h0, 26'h0, 32'h0);
    `CHK("no buffer", 1'b0, bu)
  endtask
  task automatic stop_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // slow-mode accesses dominate the run, about 33000 cycles
  initial begin
    repeat (60000) @(posedge clk_in);
    failures++;
    stop_test();
  end
  initial begin
    failures = 0;
    comparisons = 0;
    arst_n_in = 1'b0;
    req_valid_in = 1'b0;
    req = '0;
    stall = 4'h0;
    base();
    repeat (5) @(negedge clk_in);
    arst_n_in = 1'b1;
    t_read();
    t_write();
    t_lanes();
    t_refuse();
    t_turn();
    t_slow();
    stop_test();
  end
endmodule
